/* hw/epl_port_cfg_loader.sv */
// Purpose: Scatter EEPROM words into per-port configuration fields
// Assumes: Word strobe comes from the EEPROM reader on the same clock
// Notes:   Fields are read-only over AHB; only the loader writes them
//
// Chosen here: the register addresses and the AHB-Lite slave port.
module epl_port_cfg_loader
#(
   parameter int CNT_W = 16
)
(
   input  wire logic                                       clk,
   input  wire logic                                       sys_rst,
   input  epl_pkg::epl_ee_word_t                           ee_word,
   input  wire logic                                       hsel,
   input  wire logic [31:0]                                haddr,
   input  wire logic [1:0]                                 htrans,
   input  wire logic                                       hwrite,
   input  wire logic [2:0]                                 hsize,
   input  wire logic [31:0]                                hwdata,
   input  wire logic                                       hready,
   output logic                                            hreadyout,
   output logic [31:0]                                     hrdata,
   output logic                                            hresp,
   output epl_pkg::epl_port_cfg_t [epl_pkg::NUM_PORTS-1:0] port_cfg
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      epl_pkg::epl_port_cfg_t [epl_pkg::NUM_PORTS-1:0] cfg;
      logic                                            enable;
      logic [CNT_W-1:0]                                applied;
      logic [CNT_W-1:0]                                ignored;
      logic [7:0]                                      last_addr;
   } epl_ldr_state_t;

   epl_ldr_state_t        s_reg;
   epl_ldr_state_t        s_next;
   epl_pkg::epl_decode_t  dec;
   epl_pkg::epl_bus_req_t req;
   logic [31:0]           rdata;
   logic                  take;

   epl_ee_decode u_dec
   (
      .addr (ee_word.addr),
      .dec  (dec)
   );

   epl_ahb_slave u_slv
   (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp),
      .req       (req),
      .rdata     (rdata)
   );

   // ****************************************
   // Register read decode
   // ****************************************
   function automatic logic [31:0] cfg_word(input epl_pkg::epl_port_cfg_t c,
                                            input logic [7:0] off);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (off == epl_pkg::CFG_OFF_70)
         v = c.c70;
      else if (off == epl_pkg::CFG_OFF_74)
         v = c.c74;
      else if (off == epl_pkg::CFG_OFF_80)
         v = c.c80;
      else if (off == epl_pkg::CFG_OFF_88)
         v = c.c88;
      else if (off == epl_pkg::CFG_OFF_8C)
         v = c.c8c;
      else if (off == epl_pkg::CFG_OFF_D4)
         v = c.cd4;
      cfg_word = v;
   endfunction

   always_comb
   begin
      rdata = 32'h0000_0000;
      if (req.addr == epl_pkg::CTRL_ADDR)
         rdata = {31'h0000_0000, s_reg.enable};
      else if (req.addr == epl_pkg::STATUS_ADDR)
         rdata = 32'({s_reg.ignored, s_reg.applied});
      else if (req.addr == epl_pkg::LAST_ADDR)
         rdata = {24'h00_0000, s_reg.last_addr};
      else if (req.addr[11:8] < 4'(epl_pkg::NUM_PORTS))
         rdata = cfg_word(s_reg.cfg[req.addr[10:8]], req.addr[7:0]);
   end

   // ****************************************
   // Field loading
   // ****************************************
   // Strobe marks a whole word, so fields never see half a word
   assign take = ee_word.valid && s_reg.enable && dec.hit;

   always_comb
   begin
      s_next = s_reg;
      if (take)
      begin
         s_next.applied   = s_reg.applied + CNT_W'(1);
         s_next.last_addr = ee_word.addr;
         case (dec.kind)
            epl_pkg::K_PM:
            begin
               s_next.cfg[dec.port].c74[14]    = ee_word.data[6];
               s_next.cfg[dec.port].c74[13:8]  = ee_word.data[5:0];
               s_next.cfg[dec.port].c70[31]    = ee_word.data[7];
               s_next.cfg[dec.port].c88[31:24] = ee_word.data[15:8];
            end
            epl_pkg::K_SLOT_LO:
               s_next.cfg[dec.port].cd4[15:0] = ee_word.data;
            epl_pkg::K_SLOT_HI:
               s_next.cfg[dec.port].cd4[31:16] = ee_word.data;
            epl_pkg::K_PHY3_LO:
               s_next.cfg[dec.port].c80[15:0] = ee_word.data;
            epl_pkg::K_PHY3_HI:
               s_next.cfg[dec.port].c80[31:16] = ee_word.data;
            epl_pkg::K_REPLAY:
            begin
               // Same layout for all six ports
               s_next.cfg[dec.port].c70[11:0]  = ee_word.data[11:0];
               s_next.cfg[dec.port].c70[12]    = ee_word.data[12];
               s_next.cfg[dec.port].c8c[25:24] = ee_word.data[14:13];
            end
            default:
               s_next.applied = s_reg.applied;
         endcase
      end
      else if (ee_word.valid)
         s_next.ignored = s_reg.ignored + CNT_W'(1);
      // Software may pause loading; it cannot alter the fields
      if (req.valid && req.write && req.addr == epl_pkg::CTRL_ADDR)
         s_next.enable = req.wdata[0];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_reg.cfg       <= {(epl_pkg::NUM_PORTS * 6){epl_pkg::CFG_RESET}};
         s_reg.enable    <= 1'b1;
         s_reg.applied   <= '0;
         s_reg.ignored   <= '0;
         s_reg.last_addr <= 8'h00;
      end
      else
         s_reg <= s_next;
   end

   assign port_cfg = s_reg.cfg;

   // ****************************************
   // Checks
   // ****************************************
   logic [2:0] slot_port;
   logic [2:0] phy_port;
   assign slot_port = 3'((ee_word.addr - epl_pkg::EE_SLOT_LO_1ST) >> 1) + 3'h1;
   assign phy_port  = 3'((ee_word.addr - epl_pkg::EE_PHY3_LO_1ST) >> 1);

   a_pm_rxpol: assert property (
      @(posedge clk) disable iff (sys_rst)
      (take && ee_word.addr == epl_pkg::EE_PM_P5)
      |=> port_cfg[5].c74[14] == $past(ee_word.data[6]))
      else $error("rx polarity disable not loaded");

   a_pm_ctrl: assert property (
      @(posedge clk) disable iff (sys_rst)
      (take && ee_word.addr == epl_pkg::EE_PM_P5)
      |=> port_cfg[5].c74[13:8] == $past(ee_word.data[5:0]))
      else $error("pm control bits not loaded");

   a_pm_vga: assert property (
      @(posedge clk) disable iff (sys_rst)
      (take && ee_word.addr == epl_pkg::EE_PM_P5)
      |=> port_cfg[5].c70[31] == $past(ee_word.data[7]) && $stable(port_cfg[5].c70[30:0]))
      else $error("vga decode enable not loaded");

   a_pm_phy5: assert property (
      @(posedge clk) disable iff (sys_rst)
      (take && ee_word.addr == epl_pkg::EE_PM_P5)
      |=> port_cfg[5].c88 == {$past(ee_word.data[15:8]), $past(port_cfg[5].c88[23:0])})
      else $error("phy status five byte not loaded");

   a_slot_low: assert property (
      @(posedge clk) disable iff (sys_rst)
      (ee_word.valid && s_reg.enable && !ee_word.addr[0]
       && ee_word.addr >= epl_pkg::EE_SLOT_LO_1ST
       && ee_word.addr <= epl_pkg::EE_SLOT_LO_END)
      |=> port_cfg[$past(slot_port)].cd4[15:0] == $past(ee_word.data))
      else $error("slot capability low word wrong");

   a_slot_high: assert property (
      @(posedge clk) disable iff (sys_rst)
      (take && dec.kind == epl_pkg::K_SLOT_HI)
      ##1 1'b1 |-> port_cfg[$past(dec.port)].cd4[31:16] == $past(ee_word.data)
      && $past(dec.port) == 3'($past(ee_word.addr - epl_pkg::EE_SLOT_HI_1ST) >> 1) + 3'h1)
      else $error("slot capability high word wrong");

   a_phy3_low: assert property (
      @(posedge clk) disable iff (sys_rst)
      (ee_word.valid && s_reg.enable && !ee_word.addr[0]
       && ee_word.addr >= epl_pkg::EE_PHY3_LO_1ST
       && ee_word.addr <= epl_pkg::EE_PHY3_LO_END)
      |=> port_cfg[$past(phy_port)].c80[15:0] == $past(ee_word.data))
      else $error("phy status three low half wrong");

   a_phy3_high: assert property (
      @(posedge clk) disable iff (sys_rst)
      (take && dec.kind == epl_pkg::K_PHY3_HI)
      |=> port_cfg[$past(dec.port)].c80[31:16] == $past(ee_word.data)
      && $past(dec.port) == 3'($past(ee_word.addr - epl_pkg::EE_PHY3_HI_1ST) >> 1))
      else $error("phy status three high half wrong");

   a_replay_count: assert property (
      @(posedge clk) disable iff (sys_rst)
      (take && dec.kind == epl_pkg::K_REPLAY)
      |=> port_cfg[$past(dec.port)].c70[11:0] == $past(ee_word.data[11:0]))
      else $error("replay time-out value wrong");

   a_replay_user: assert property (
      @(posedge clk) disable iff (sys_rst)
      (take && dec.kind == epl_pkg::K_REPLAY)
      |=> port_cfg[$past(dec.port)].c70[12] == $past(ee_word.data[12]))
      else $error("user replay enable wrong");

   a_train_rep: assert property (
      @(posedge clk) disable iff (sys_rst)
      (take && dec.kind == epl_pkg::K_REPLAY)
      |=> port_cfg[$past(dec.port)].c8c[25:24] == $past(ee_word.data[14:13]))
      else $error("training set repeat count wrong");

   a_replay_p5: assert property (
      @(posedge clk) disable iff (sys_rst)
      (take && ee_word.addr == epl_pkg::EE_REPLAY_END)
      |=> port_cfg[5].c70[12:0] == $past(ee_word.data[12:0])
      && port_cfg[5].c8c[25:24] == $past(ee_word.data[14:13]))
      else $error("port 5 replay word misplaced");

   a_hold_fields: assert property (
      @(posedge clk) disable iff (sys_rst)
      !take |=> $stable(port_cfg))
      else $error("field changed without a loaded word");

   a_count_words: assert property (
      @(posedge clk) disable iff (sys_rst)
      ee_word.valid |=> (s_reg.applied != $past(s_reg.applied))
      != (s_reg.ignored != $past(s_reg.ignored)))
      else $error("word neither applied nor ignored");

endmodule

/* inc/epl_pkg.sv */
// Purpose: Shared constants and types for the EEPROM port config loader
// Assumes: EEPROM words arrive whole, one per strobe, on the core clock
// Notes:   Port fields at byte address = port * 100h + cfg offset; control, status and last address at 600h-608h
package epl_pkg;

   // ****************************************
   // EEPROM word addresses
   // ****************************************
   localparam logic [7:0] EE_PM_P5       = 8'h8A;
   localparam logic [7:0] EE_SLOT_LO_1ST = 8'h92;
   localparam logic [7:0] EE_SLOT_LO_END = 8'h9A;
   localparam logic [7:0] EE_SLOT_HI_1ST = 8'hA2;
   localparam logic [7:0] EE_SLOT_HI_END = 8'hAA;
   localparam logic [7:0] EE_PHY3_LO_1ST = 8'hB0;
   localparam logic [7:0] EE_PHY3_LO_END = 8'hBA;
   localparam logic [7:0] EE_PHY3_HI_1ST = 8'hC0;
   localparam logic [7:0] EE_PHY3_HI_END = 8'hCA;
   localparam logic [7:0] EE_REPLAY_1ST  = 8'hD0;
   localparam logic [7:0] EE_REPLAY_END  = 8'hDA;
   localparam logic [2:0] PM_PORT        = 3'h5;
   localparam logic [2:0] SLOT_1ST_PORT  = 3'h1;
   localparam logic [2:0] PORT_ZERO      = 3'h0;
   localparam int         NUM_PORTS      = 6;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  CFG_OFF_70  = 8'h70;
   localparam logic [7:0]  CFG_OFF_74  = 8'h74;
   localparam logic [7:0]  CFG_OFF_80  = 8'h80;
   localparam logic [7:0]  CFG_OFF_88  = 8'h88;
   localparam logic [7:0]  CFG_OFF_8C  = 8'h8C;
   localparam logic [7:0]  CFG_OFF_D4  = 8'hD4;
   localparam logic [11:0] CTRL_ADDR   = 12'h600;
   localparam logic [11:0] STATUS_ADDR = 12'h604;
   localparam logic [11:0] LAST_ADDR   = 12'h608;
   localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
   localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

   typedef struct packed {
      logic [31:0] c70;
      logic [31:0] c74;
      logic [31:0] c80;
      logic [31:0] c88;
      logic [31:0] c8c;
      logic [31:0] cd4;
   } epl_port_cfg_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  addr;
      logic [15:0] data;
   } epl_ee_word_t;

   typedef enum logic [6:0] {
      K_NONE    = 7'h01,
      K_PM      = 7'h02,
      K_SLOT_LO = 7'h04,
      K_SLOT_HI = 7'h08,
      K_PHY3_LO = 7'h10,
      K_PHY3_HI = 7'h20,
      K_REPLAY  = 7'h40
   } epl_kind_t;

   typedef struct packed {
      logic      hit;
      epl_kind_t kind;
      logic [2:0] port;
   } epl_decode_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } epl_bus_req_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_BUSY = 3'h2,
      S_DONE = 3'h4
   } epl_bus_state_t;

endpackage

/* hw/epl_ee_decode.sv */
// Purpose: Map an EEPROM word address onto a field group and a port
// Assumes: Word addresses are even; odd ones miss
// Notes:   Purely combinational
module epl_ee_decode
(
   input  wire logic [7:0]          addr,
   output epl_pkg::epl_decode_t     dec
);

   function automatic logic in_range(input logic [7:0] a,
                                     input logic [7:0] first,
                                     input logic [7:0] last);
      in_range = (a >= first) && (a <= last) && !a[0];
   endfunction

   function automatic logic [2:0] port_of(input logic [7:0] a,
                                          input logic [7:0] first,
                                          input logic [2:0] port0);
      logic [7:0] diff;
      diff = a - first;
      port_of = diff[3:1] + port0;
   endfunction

   always_comb
   begin
      dec = '{hit: 1'b0, kind: epl_pkg::K_NONE, port: epl_pkg::PORT_ZERO};
      if (addr == epl_pkg::EE_PM_P5)
         dec = '{1'b1, epl_pkg::K_PM, epl_pkg::PM_PORT};
      else if (in_range(addr, epl_pkg::EE_SLOT_LO_1ST, epl_pkg::EE_SLOT_LO_END))
         dec = '{1'b1, epl_pkg::K_SLOT_LO,
                 port_of(addr, epl_pkg::EE_SLOT_LO_1ST, epl_pkg::SLOT_1ST_PORT)};
      else if (in_range(addr, epl_pkg::EE_SLOT_HI_1ST, epl_pkg::EE_SLOT_HI_END))
         dec = '{1'b1, epl_pkg::K_SLOT_HI,
                 port_of(addr, epl_pkg::EE_SLOT_HI_1ST, epl_pkg::SLOT_1ST_PORT)};
      else if (in_range(addr, epl_pkg::EE_PHY3_LO_1ST, epl_pkg::EE_PHY3_LO_END))
         dec = '{1'b1, epl_pkg::K_PHY3_LO,
                 port_of(addr, epl_pkg::EE_PHY3_LO_1ST, epl_pkg::PORT_ZERO)};
      else if (in_range(addr, epl_pkg::EE_PHY3_HI_1ST, epl_pkg::EE_PHY3_HI_END))
         dec = '{1'b1, epl_pkg::K_PHY3_HI,
                 port_of(addr, epl_pkg::EE_PHY3_HI_1ST, epl_pkg::PORT_ZERO)};
      else if (in_range(addr, epl_pkg::EE_REPLAY_1ST, epl_pkg::EE_REPLAY_END))
         dec = '{1'b1, epl_pkg::K_REPLAY,
                 port_of(addr, epl_pkg::EE_REPLAY_1ST, epl_pkg::PORT_ZERO)};
   end

endmodule

/* hw/epl_ahb_slave.sv */
// Purpose: AHB-Lite slave front end with one wait state per transfer
// Assumes: Single whole-word transfers; response always OKAY
// Notes:   Write lands at the end of the wait cycle; read data registered
module epl_ahb_slave
(
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic [31:0]                hrdata,
   output logic                       hresp,
   output epl_pkg::epl_bus_req_t      req,
   input  wire logic [31:0]           rdata
);

   typedef struct packed {
      epl_pkg::epl_bus_state_t st;
      logic                    write;
      logic [11:0]             addr;
      logic [31:0]             rdata;
   } epl_slv_state_t;

   epl_slv_state_t s_reg;
   epl_slv_state_t s_next;

   always_comb
   begin
      s_next = s_reg;
      req    = '{valid: s_reg.st == epl_pkg::S_BUSY, write: s_reg.write,
                 addr: s_reg.addr, wdata: hwdata};
      case (s_reg.st)
         epl_pkg::S_BUSY:
         begin
            s_next.rdata = rdata;
            s_next.st    = epl_pkg::S_DONE;
         end
         default:
         begin
            s_next.st = epl_pkg::S_IDLE;
            if (hsel && hready && htrans == epl_pkg::HTRANS_NSEQ)
            begin
               s_next.st    = epl_pkg::S_BUSY;
               s_next.write = hwrite;
               s_next.addr  = haddr[11:0];
            end
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         s_reg <= '{st: epl_pkg::S_IDLE, write: 1'b0, addr: 12'h000, rdata: 32'h0000_0000};
      else
         s_reg <= s_next;
   end

   assign hreadyout = s_reg.st != epl_pkg::S_BUSY;
   assign hrdata    = s_reg.rdata;
   assign hresp     = 1'b0;

endmodule

/* tb/epl_ee_model.sv */
// Purpose: Far-side model of the serial EEPROM reader that hands words over
// Assumes: Bench drives req right after a rising edge, one word per cycle
// Notes:   Between words addr and data show a changing pattern, never old data
module epl_ee_model
(
   input  wire logic             clk,
   input  epl_pkg::epl_ee_word_t req,
   output epl_pkg::epl_ee_word_t ee_word
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [23:0] idle_pat_reg = 24'hA5C396;

   always @(posedge clk)
   begin
      idle_pat_reg <= ~{idle_pat_reg[22:0], idle_pat_reg[23]};
   end

   // Only whole words are offered; a stale word must not look fresh
   assign ee_word = req.valid ? req : {1'b0, idle_pat_reg};
endmodule

/* tb/epl_port_cfg_loader_bench.sv */
// Purpose: Self-checking bench for the EEPROM port config loader
// Assumes: One AHB-Lite master, one slave; hready is the slave's hreadyout
// Notes:   Expected images are rebuilt here from the word map alone
module epl_port_cfg_loader_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic                                           clk;
   logic                                           sys_rst;
   logic                                           hsel;
   logic                                           hwrite;
   logic [31:0]                                    haddr;
   logic [31:0]                                    hwdata;
   logic [1:0]                                     htrans;
   logic [2:0]                                     hsize;
   logic                                           hreadyout;
   logic                                           hresp;
   logic [31:0]                                    hrdata;
   logic [31:0]                                    rd;
   epl_pkg::epl_ee_word_t                          req;
   epl_pkg::epl_ee_word_t                          ee_word;
   epl_pkg::epl_port_cfg_t [epl_pkg::NUM_PORTS-1:0] port_cfg;
   epl_pkg::epl_port_cfg_t [epl_pkg::NUM_PORTS-1:0] exp_cfg;
   logic                                           en;
   logic [15:0]                                    n_app;
   logic [15:0]                                    n_ign;
   logic [7:0]                                     last_a;
   logic [7:0]                                     q[$];
   logic [7:0]                                     offs[6];
   int                                             err_total;
   int                                             samples_checked;

   epl_ee_model i_ee (.clk(clk), .req(req), .ee_word(ee_word));

   epl_port_cfg_loader i_dut
   (
      .clk(clk), .sys_rst(sys_rst), .ee_word(ee_word), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .port_cfg(port_cfg)
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ****************************************
   // Reference and checks
   // ****************************************
   function automatic void reset_exp();
      exp_cfg = {36{epl_pkg::CFG_RESET}};
      en = 1'b1;
      n_app = 16'h0000;
      n_ign = 16'h0000;
      last_a = 8'h00;
   endfunction

   function automatic void apply(logic [7:0] a, logic [15:0] d);
      logic [2:0] p;
      logic       ok;
      ok = en && !a[0];
      p = 3'(a[7:1] - epl_pkg::EE_PM_P5[7:1]);
      if (ok && a == epl_pkg::EE_PM_P5)
      begin
         exp_cfg[5].c74[14:8] = d[6:0];
         exp_cfg[5].c70[31] = d[7];
         exp_cfg[5].c88[31:24] = d[15:8];
      end
      else if (ok && a inside {[epl_pkg::EE_SLOT_LO_1ST:epl_pkg::EE_SLOT_LO_END]})
         exp_cfg[3'(a[7:1] - 7'h49) + 3'h1].cd4[15:0] = d;
      else if (ok && a inside {[epl_pkg::EE_SLOT_HI_1ST:epl_pkg::EE_SLOT_HI_END]})
         exp_cfg[3'(a[7:1] - 7'h51) + 3'h1].cd4[31:16] = d;
      else if (ok && a inside {[epl_pkg::EE_PHY3_LO_1ST:epl_pkg::EE_PHY3_LO_END]})
         exp_cfg[3'(a[7:1] - 7'h58)].c80[15:0] = d;
      else if (ok && a inside {[epl_pkg::EE_PHY3_HI_1ST:epl_pkg::EE_PHY3_HI_END]})
         exp_cfg[3'(a[7:1] - 7'h60)].c80[31:16] = d;
      else if (ok && a inside {[epl_pkg::EE_REPLAY_1ST:epl_pkg::EE_REPLAY_END]})
      begin
         p = 3'(a[7:1] - 7'h68);
         exp_cfg[p].c70[12:0] = d[12:0];
         exp_cfg[p].c8c[25:24] = d[14:13];
      end
      else
         ok = 1'b0;
      if (ok)
      begin
         n_app++;
         last_a = a;
      end
      else
         n_ign++;
   endfunction

   function automatic logic [31:0] field(int p, int k);
      case (k)
         0: return exp_cfg[p].c70;
         1: return exp_cfg[p].c74;
         2: return exp_cfg[p].c80;
         3: return exp_cfg[p].c88;
         4: return exp_cfg[p].c8c;
         default: return exp_cfg[p].cd4;
      endcase
   endfunction

   task automatic check(input logic [191:0] got, input logic [191:0] want, input string what);
      samples_checked++;
      if (got !== want)
      begin
         err_total++;
         $display("FAIL at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask

   // ****************************************
   // Drivers
   // ****************************************
   // Waits are bounded so a stuck slave cannot hang the run
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      htrans <= epl_pkg::HTRANS_NSEQ;
      @(negedge clk);
      while (hreadyout !== 1'b1 && n < 50)
      begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(negedge clk);
      while (hreadyout !== 1'b1 && n < 50)
      begin
         @(negedge clk);
         n++;
      end
      rdv = hrdata;
      check(hresp, 1'b0, "bus response");
      @(posedge clk);
      if (n >= 50)
      begin
         err_total++;
         $display("FAIL at %0t: bus transfer never completed", $time);
      end
   endtask

   task automatic ee_send(input logic [7:0] a, input logic [15:0] d);
      req <= '{1'b1, a, d};
      @(posedge clk);
      apply(a, d);
   endtask

   task automatic ee_stop();
      req.valid <= 1'b0;
      @(posedge clk);
   endtask

   task automatic check_all();
      @(negedge clk);
      for (int p = 0; p < epl_pkg::NUM_PORTS; p++)
         check(port_cfg[p], exp_cfg[p], "port image");
      @(posedge clk);
      ahb(1'b0, {20'h0, epl_pkg::STATUS_ADDR}, 32'h0, rd);
      check(rd, {n_ign, n_app}, "word counts");
      ahb(1'b0, {20'h0, epl_pkg::LAST_ADDR}, 32'h0, rd);
      check(rd, {24'h0, last_a}, "last word address");
   endtask

   task automatic conclude();
      $display("summary: %0d checked, %0d mismatches", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge clk);
      err_total++;
      $display("FAIL at %0t: watchdog expired", $time);
      conclude();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      req = '0;
      err_total = 0;
      samples_checked = 0;
      offs = '{epl_pkg::CFG_OFF_70, epl_pkg::CFG_OFF_74, epl_pkg::CFG_OFF_80,
               epl_pkg::CFG_OFF_88, epl_pkg::CFG_OFF_8C, epl_pkg::CFG_OFF_D4};
      reset_exp();
      void'($urandom(44364));
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      // Reset images, enable default, unmapped and read-only places
      check_all();
      ahb(1'b0, {20'h0, epl_pkg::CTRL_ADDR}, 32'h0, rd);
      check(rd, 32'h1, "enable reset value");
      ahb(1'b1, 32'h0000_0570, 32'hFFFF_FFFF, rd);
      ahb(1'b1, 32'h0000_0700, 32'hFFFF_FFFF, rd);
      ahb(1'b0, 32'h0000_0570, 32'h0, rd);
      check(rd, 32'h0, "read-only field after write");
      ahb(1'b0, 32'h0000_0700, 32'h0, rd);
      check(rd, 32'h0, "unmapped read");
      $display("test reset_values done");
      // Every mapped word back to back, power-management word at all ones first
      ee_send(epl_pkg::EE_PM_P5, 16'hFFFF);
      ee_stop();
      check_all();
      q.push_back(epl_pkg::EE_PM_P5);
      for (int i = 0; i < 6; i++)
      begin
         if (i < 5)
         begin
            q.push_back(8'(epl_pkg::EE_SLOT_LO_1ST + 2 * i));
            q.push_back(8'(epl_pkg::EE_SLOT_HI_1ST + 2 * i));
         end
         q.push_back(8'(epl_pkg::EE_PHY3_LO_1ST + 2 * i));
         q.push_back(8'(epl_pkg::EE_PHY3_HI_1ST + 2 * i));
         q.push_back(8'(epl_pkg::EE_REPLAY_1ST + 2 * i));
      end
      foreach (q[i])
         ee_send(q[i], 16'($urandom));
      ee_stop();
      check_all();
      for (int p = 0; p < 6; p++)
         for (int k = 0; k < 6; k++)
         begin
            ahb(1'b0, 32'(p * 256) + {24'h0, offs[k]}, 32'h0, rd);
            check(rd, field(p, k), "field readback");
         end
      $display("test all_words done");
      // Random words, odd and unmapped addresses among them
      repeat (150)
      begin
         ee_send(8'h80 + 8'($urandom_range(0, 99)), 16'($urandom));
         ee_stop();
         check_all();
      end
      $display("test random_words done");
      // Loading disabled: words are counted as ignored, images unchanged
      ahb(1'b1, {20'h0, epl_pkg::CTRL_ADDR}, 32'h0, rd);
      en = 1'b0;
      ee_send(epl_pkg::EE_PHY3_LO_1ST, 16'h1234);
      ee_send(epl_pkg::EE_REPLAY_END, 16'h7FFF);
      ee_stop();
      check_all();
      ahb(1'b1, {20'h0, epl_pkg::CTRL_ADDR}, 32'h1, rd);
      en = 1'b1;
      ee_send(epl_pkg::EE_REPLAY_END, 16'h6ABC);
      ee_stop();
      check_all();
      $display("test disable done");
      // Reset in mid-run clears every field again
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      reset_exp();
      @(posedge clk);
      check_all();
      $display("test mid_reset done");
      conclude();
   end
endmodule
